// File: logic/fwp_defs.svh
// constants of the flash write protection block
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH
`define FWP_OTP_BYTES     32'h0000_0400
`define FWP_ARRAY_BYTES   24'h80_0000
`define FWP_BP_BASE_SHIFT 5'h10
`define FWP_REG_STATUS    8'h00
`define FWP_REG_CONFIG    8'h04
`define FWP_REG_LOCK      8'h08
`define FWP_REG_ECC_LO    8'h0C
`define FWP_REG_ECC_HI    8'h10
`define FWP_REG_CLEAR     8'h14
`define FWP_ST_WEL        1
`define FWP_ST_BP_LO      2
`define FWP_ST_EERR       5
`define FWP_ST_PERR       6
`define FWP_ST_STATUS_WRITE_DISABLE       7
`define FWP_CF_FREEZE     0
`define FWP_CF_TBPROT     5
`define FWP_LOCK_RESET    32'hFFFF_FFFF
`define FWP_EDGE_MAX      4'hF
`endif

// File: logic/fwp_pkg.sv
// types of the flash write protection block
`default_nettype none

package fwp_pkg;
    typedef enum logic [4:0] {
        FWP_NO_CMD,
        FWP_WRITE_ENABLE_CMD,
        FWP_WRITE_DISABLE_CMD,
        FWP_WRITE_STATUS_CONFIG_CMD,
        FWP_WRITE_ANY_REG_CMD,
        FWP_PAGE_PROGRAM_CMD,
        FWP_SMALL_SECTOR_ERASE_CMD,
        FWP_SECTOR_ERASE_CMD,
        FWP_BULK_ERASE_CMD,
        FWP_OTP_PROGRAM_CMD,
        FWP_OTP_READ_CMD,
        FWP_SECTOR_PROT_REG_PROGRAM_CMD,
        FWP_PERSIST_BIT_PROGRAM_CMD,
        FWP_PERSIST_BIT_ERASE_CMD,
        FWP_PASSWORD_PROGRAM_CMD,
        FWP_LEARN_PATTERN_PROGRAM_CMD,
        FWP_SOFT_RESET_CMD
    } fwp_cmd_t;

    typedef struct packed {
        fwp_cmd_t    cmd;
        logic [31:0] addr;
        logic [15:0] data;
    } fwp_req_t;

    typedef struct packed {
        logic        valid;
        fwp_cmd_t    cmd;
        logic [31:0] addr;
        logic        eccOn;
    } fwp_go_t;

    typedef struct packed {
        logic        sckS1;
        logic        sckS2;
        logic        sckD;
        logic        csS1;
        logic        csS2;
        logic        csD;
        logic        wpS1;
        logic        wpS2;
        logic [3:0]  edgeCnt;
        logic        write_latch_flag;
        logic [2:0]  bp;
        logic        eerr;
        logic        perr;
        logic        status_write_disable;
        logic        freeze;
        logic        tbprot;
        logic [31:0] lock;
        logic [63:0] sliceDone;
        logic [63:0] eccOff;
        logic [31:0] rdata;
        fwp_go_t     go;
    } fwp_state_t;
endpackage : fwp_pkg

`default_nettype wire

// File: logic/fwp_write_protect.sv
// write protection gate of a serial flash: latch, block range, freeze, pin, otp locks
`timescale 1ns/100ps
`default_nettype none
`include "fwp_defs.svh"

module fwp_write_protect (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              sck,
    input  wire logic              csN,
    input  wire logic              wpN,
    input  wire fwp_pkg::fwp_req_t req,
    input  wire logic              ppbBit,
    input  wire logic              dybBit,
    input  wire logic [7:0]        busAddr,
    input  wire logic [31:0]       busWdata,
    input  wire logic              busWr,
    input  wire logic              busRd,
    output logic [31:0]            busRdata,
    output fwp_pkg::fwp_go_t       opGo
);
    import fwp_pkg::*;

    fwp_state_t st_ff;
    fwp_state_t nxt_st;

    logic        csRise;
    logic        frameOk;
    logic        inRange;
    logic [4:0]  region;
    logic [5:0]  slice;
    logic        lockOk;
    logic [23:0] bpSize;
    logic [23:0] addrLow;
    logic        bpHit;
    logic        secProt;
    logic        wpBlock;
    logic [7:0]  statusByte;
    logic [7:0]  configByte;

    // a frame needs at least one clock edge; a bare select pulse is noise
    assign csRise  = st_ff.csS2 & ~st_ff.csD;
    assign frameOk = csRise & (st_ff.edgeCnt != 4'h0);
    assign inRange = req.addr < `FWP_OTP_BYTES;
    assign region  = req.addr[9:5];
    assign slice   = req.addr[9:4];
    // region zero lower half holds no lock bit of its own
    assign lockOk  = (region == 5'h00) ? (~req.addr[4] | st_ff.lock[0])
                                       : st_ff.lock[region];
    assign bpSize  = 24'h00_0001 << (`FWP_BP_BASE_SHIFT + {2'b00, st_ff.bp});
    assign addrLow = {1'b0, req.addr[22:0]};
    // code 111 gives the full 8MB, so one compare serves every nonzero code
    assign bpHit   = (st_ff.bp != 3'h0) &&
                     (st_ff.tbprot ? (addrLow < bpSize)
                                   : (addrLow >= (`FWP_ARRAY_BYTES - bpSize)));
    assign secProt = bpHit | ~ppbBit | ~dybBit;
    assign wpBlock = ~st_ff.wpS2 & st_ff.status_write_disable;
    assign statusByte = {st_ff.status_write_disable, st_ff.perr, st_ff.eerr, st_ff.bp, st_ff.write_latch_flag, 1'b0};
    assign configByte = {2'b00, st_ff.tbprot, 4'h0, st_ff.freeze};

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sckS1 = sck;
        nxt_st.sckS2 = st_ff.sckS1;
        nxt_st.sckD  = st_ff.sckS2;
        nxt_st.csS1  = csN;
        nxt_st.csS2  = st_ff.csS1;
        nxt_st.csD   = st_ff.csS2;
        nxt_st.wpS1  = wpN;
        nxt_st.wpS2  = st_ff.wpS1;
        nxt_st.go.valid = 1'b0;
        nxt_st.rdata = 32'h0000_0000;
        if (st_ff.csS2) begin
            nxt_st.edgeCnt = 4'h0;
        end else if (st_ff.sckS2 & ~st_ff.sckD & (st_ff.edgeCnt != `FWP_EDGE_MAX)) begin
            nxt_st.edgeCnt = st_ff.edgeCnt + 4'h1;
        end
        // bus clear goes first so a same-cycle error event wins
        if (busWr && (busAddr == `FWP_REG_CLEAR)) begin
            if (busWdata[`FWP_ST_EERR]) begin
                nxt_st.eerr = 1'b0;
            end
            if (busWdata[`FWP_ST_PERR]) begin
                nxt_st.perr = 1'b0;
            end
        end
        if (busRd) begin
            case (busAddr)
                `FWP_REG_STATUS: nxt_st.rdata = {24'h00_0000, statusByte};
                `FWP_REG_CONFIG: nxt_st.rdata = {24'h00_0000, configByte};
                `FWP_REG_LOCK:   nxt_st.rdata = st_ff.lock;
                `FWP_REG_ECC_LO: nxt_st.rdata = st_ff.eccOff[31:0];
                `FWP_REG_ECC_HI: nxt_st.rdata = st_ff.eccOff[63:32];
                default:         nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        if (frameOk) begin
            nxt_st.go.cmd   = req.cmd;
            nxt_st.go.addr  = req.addr;
            nxt_st.go.eccOn = 1'b0;
            case (req.cmd)
                FWP_WRITE_ENABLE_CMD: begin
                    nxt_st.write_latch_flag = 1'b1;
                end
                FWP_WRITE_DISABLE_CMD, FWP_SOFT_RESET_CMD: begin
                    nxt_st.write_latch_flag = 1'b0;
                end
                FWP_OTP_READ_CMD: begin
                    // no range check: the array answers past 1KB with junk
                    nxt_st.go.valid = 1'b1;
                end
                FWP_WRITE_STATUS_CONFIG_CMD, FWP_WRITE_ANY_REG_CMD: begin
                    if (st_ff.write_latch_flag) begin
                        nxt_st.write_latch_flag = 1'b0;
                        if (!wpBlock) begin
                            nxt_st.status_write_disable = req.data[`FWP_ST_STATUS_WRITE_DISABLE];
                            if (!st_ff.freeze) begin
                                nxt_st.bp     = req.data[`FWP_ST_BP_LO +: 3];
                                nxt_st.tbprot = req.data[8 + `FWP_CF_TBPROT];
                            end
                            // freeze only sets; a reset is the only way back
                            nxt_st.freeze = st_ff.freeze | req.data[8 + `FWP_CF_FREEZE];
                        end
                    end
                end
                FWP_PAGE_PROGRAM_CMD, FWP_SMALL_SECTOR_ERASE_CMD,
                FWP_SECTOR_ERASE_CMD, FWP_BULK_ERASE_CMD: begin
                    if (st_ff.write_latch_flag) begin
                        nxt_st.write_latch_flag = 1'b0;
                        // bulk erase is refused while any code is set
                        if (secProt || ((req.cmd == FWP_BULK_ERASE_CMD) && (st_ff.bp != 3'h0))) begin
                            if (req.cmd == FWP_PAGE_PROGRAM_CMD) begin
                                nxt_st.perr = 1'b1;
                            end else begin
                                nxt_st.eerr = 1'b1;
                            end
                        end else begin
                            nxt_st.go.valid = 1'b1;
                        end
                    end
                end
                FWP_OTP_PROGRAM_CMD: begin
                    if (st_ff.write_latch_flag) begin
                        nxt_st.write_latch_flag = 1'b0;
                        if (!inRange) begin
                            nxt_st.write_latch_flag = 1'b0;
                        end else if (st_ff.freeze || !lockOk) begin
                            nxt_st.perr = 1'b1;
                        end else begin
                            nxt_st.go.valid = 1'b1;
                            nxt_st.go.eccOn = ~st_ff.sliceDone[slice];
                            nxt_st.sliceDone[slice] = 1'b1;
                            nxt_st.eccOff[slice] = st_ff.sliceDone[slice];
                            if (req.addr[9:2] == 8'h04) begin
                                nxt_st.lock = st_ff.lock;
                                nxt_st.lock[req.addr[1:0]*8 +: 8] =
                                    st_ff.lock[req.addr[1:0]*8 +: 8] & req.data[7:0];
                            end
                        end
                    end
                end
                FWP_SECTOR_PROT_REG_PROGRAM_CMD, FWP_PERSIST_BIT_PROGRAM_CMD,
                FWP_PERSIST_BIT_ERASE_CMD, FWP_PASSWORD_PROGRAM_CMD,
                FWP_LEARN_PATTERN_PROGRAM_CMD: begin
                    if (st_ff.write_latch_flag) begin
                        nxt_st.write_latch_flag = 1'b0;
                        nxt_st.go.valid = 1'b1;
                    end
                end
                default: begin
                    nxt_st.go.valid = 1'b0;
                end
            endcase
        end
    end

    // nonvolatile bits live in flops here, so reset stands in for power cycling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.sckS1 <= 1'b0;
            st_ff.csS1  <= 1'b1;
            st_ff.csS2  <= 1'b1;
            st_ff.csD   <= 1'b1;
            st_ff.wpS1  <= 1'b1;
            st_ff.wpS2  <= 1'b1;
            st_ff.lock  <= `FWP_LOCK_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busRdata = st_ff.rdata;
    assign opGo     = st_ff.go;

    a_wel_set_on_enable: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && req.cmd == FWP_WRITE_ENABLE_CMD |=> st_ff.write_latch_flag)
        else $error("latch not set by write enable");
    a_wel_gate_program: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && !st_ff.write_latch_flag && req.cmd == FWP_PAGE_PROGRAM_CMD |=> !opGo.valid)
        else $error("program passed with latch clear");
    a_wel_clear_done: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_SECTOR_ERASE_CMD |=> !st_ff.write_latch_flag)
        else $error("latch left set after erase");
    a_otp_range_drop: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_OTP_PROGRAM_CMD && !inRange
        |=> !opGo.valid && !$rose(st_ff.perr))
        else $error("out of range otp program not dropped");
    a_otp_freeze_fail: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_OTP_PROGRAM_CMD && inRange && st_ff.freeze
        |=> st_ff.perr && !opGo.valid)
        else $error("frozen otp program did not fail");
    a_freeze_holds_bp: assert property (@(posedge clk) disable iff (!rst_n)
        st_ff.freeze |=> $stable(st_ff.bp) && $stable(st_ff.tbprot) && st_ff.freeze)
        else $error("block controls moved while frozen");
    a_wp_pin_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && wpBlock && req.cmd == FWP_WRITE_STATUS_CONFIG_CMD
        |=> $stable(st_ff.status_write_disable) && $stable(st_ff.bp) && $stable(st_ff.freeze))
        else $error("status write passed under write protect");
    a_protected_erase: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_SECTOR_ERASE_CMD && (!ppbBit || !dybBit)
        |=> st_ff.eerr && !opGo.valid)
        else $error("erase of guarded sector not refused");
    a_ecc_second_off: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_OTP_PROGRAM_CMD && inRange && !st_ff.freeze
        && lockOk && st_ff.sliceDone[slice] |=> opGo.valid && !opGo.eccOn)
        else $error("ecc left on for reprogrammed slice");
    a_top_range_hit: assert property (@(posedge clk) disable iff (!rst_n)
        frameOk && st_ff.write_latch_flag && req.cmd == FWP_PAGE_PROGRAM_CMD && st_ff.bp == 3'h1
        && !st_ff.tbprot && req.addr[22:17] == 6'h3F |=> st_ff.perr && !opGo.valid)
        else $error("top 128KB not guarded by code 001");
endmodule : fwp_write_protect

`default_nettype wire

// File: verification/fwp_spi_host.sv
// spi host model: one decoded command per chip-select frame
`timescale 1ns/100ps
`default_nettype none

module fwp_spi_host (
    input  wire logic              clk,
    output var  logic              sck,
    output var  logic              csN,
    output var  fwp_pkg::fwp_req_t req
);
    import fwp_pkg::*;

    initial begin
        sck = 1'b0;
        csN = 1'b1;
        req = '0;
    end

    // reads, programs and register writes share one framing
    task automatic send(input fwp_cmd_t c, input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{c, a, d};
        csN <= 1'b0;
        // 3.5ns offset: the first sck rise lands on a falling clk edge, the later three edges clear both clk edges
        #3.5;
        // sck only toggles inside the frame, phase unrelated to clk
        repeat (2) begin
            #24 sck = 1'b1;
            #24 sck = 1'b0;
        end
        @(posedge clk);
        csN <= 1'b1;
        repeat (6) @(posedge clk);
        // hold time over: a changed pattern, never the last value
        req <= fwp_req_t'(~req);
        repeat (4) @(posedge clk);
    endtask : send

    // every altering command goes out behind a write enable
    task automatic wsend(input fwp_cmd_t c, input logic [31:0] a, input logic [15:0] d);
        send(FWP_WRITE_ENABLE_CMD, 32'h0, 16'h0);
        send(c, a, d);
    endtask : wsend
endmodule : fwp_spi_host

`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the flash write protection gate
`timescale 1ns/100ps
`default_nettype none
`include "fwp_defs.svh"

module tb_top;
    import fwp_pkg::*;
    localparam fwp_cmd_t cPp  = FWP_PAGE_PROGRAM_CMD;
    localparam fwp_cmd_t cOtp = FWP_OTP_PROGRAM_CMD;
    localparam fwp_cmd_t cWr  = FWP_WRITE_STATUS_CONFIG_CMD;
    logic        clk;
    logic        rst_n;
    logic        wpN;
    logic        ppbBit;
    logic        dybBit;
    logic [7:0]  busAddr;
    logic [31:0] busWdata;
    logic        busWr;
    logic        busRd;
    logic [31:0] busRdata;
    logic        sck;
    logic        csN;
    fwp_req_t    req;
    fwp_go_t     opGo;
    fwp_go_t     lastGo;
    int          fails;
    int          checks_done;
    int          goCnt;
    logic [31:0] v;

    fwp_spi_host host (.clk(clk), .sck(sck), .csN(csN), .req(req));
    fwp_write_protect uut (.clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .wpN(wpN), .req(req),
        .ppbBit(ppbBit), .dybBit(dybBit), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .opGo(opGo));

    // write enable grants are left out so refusals can be counted cleanly
    always @(posedge clk) begin
        if (opGo.valid === 1'b1 && opGo.cmd !== FWP_WRITE_ENABLE_CMD) begin
            goCnt <= goCnt + 1;
            lastGo <= opGo;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        if (fails == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        @(negedge clk);
        v = busRdata;
    endtask : rd

    task automatic reset_dut;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : reset_dut

    task automatic op(input fwp_cmd_t c, input logic [31:0] a, input logic [7:0] d,
                      input logic w, input logic g);
        int n;
        n = goCnt;
        if (w) host.wsend(c, a, {8'h00, d});
        else host.send(c, a, {8'h00, d});
        chk(goCnt != n, g);
        if (g) chk(lastGo.addr, a);
        if (g) chk(lastGo.cmd, c);
        rd(`FWP_REG_STATUS);
        chk(v[1], 1'b0);
    endtask : op

    function automatic logic prot(input logic [2:0] bp, input logic tb, input logic [31:0] a);
        logic [31:0] size;
        size = (bp == 3'h0) ? 32'h0 : (32'h0002_0000 << (bp - 3'h1));
        return tb ? (a < size) : (a >= 32'h0080_0000 - size);
    endfunction : prot

    task automatic t_reset;
        logic [7:0]  ra [4] = '{`FWP_REG_STATUS, `FWP_REG_CONFIG, `FWP_REG_LOCK, 8'h20};
        logic [31:0] rv [4] = '{32'h0, 32'h0, `FWP_LOCK_RESET, 32'h0};
        wr(`FWP_REG_STATUS, 32'hFFFF_FFFF);
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(v, rv[i]);
        end
    endtask : t_reset

    task automatic t_latch;
        fwp_cmd_t ac [5] = '{FWP_SECTOR_PROT_REG_PROGRAM_CMD, FWP_PERSIST_BIT_PROGRAM_CMD,
                             FWP_PERSIST_BIT_ERASE_CMD, FWP_PASSWORD_PROGRAM_CMD,
                             FWP_LEARN_PATTERN_PROGRAM_CMD};
        op(cPp, 32'h0000_1000, 8'h00, 1'b0, 1'b0);
        op(cPp, 32'h0000_1000, 8'h00, 1'b1, 1'b1);
        host.send(FWP_WRITE_ENABLE_CMD, 32'h0, 16'h0);
        rd(`FWP_REG_STATUS);
        chk(v[1], 1'b1);
        host.send(FWP_WRITE_DISABLE_CMD, 32'h0, 16'h0);
        rd(`FWP_REG_STATUS);
        chk(v[1], 1'b0);
        host.send(FWP_WRITE_ENABLE_CMD, 32'h0, 16'h0);
        host.send(FWP_SOFT_RESET_CMD, 32'h0, 16'h0);
        rd(`FWP_REG_STATUS);
        chk(v[1], 1'b0);
        foreach (ac[i]) begin
            op(ac[i], 32'h0, 8'h00, 1'b0, 1'b0);
            op(ac[i], 32'h0, 8'h00, 1'b1, 1'b1);
        end
    endtask : t_latch

    task automatic t_block;
        logic [31:0] ad [8] = '{32'h0, 32'h01_FFFF, 32'h02_0000, 32'h3F_FFFF,
                                32'h40_0000, 32'h7D_FFFF, 32'h7E_0000, 32'h7F_FFFF};
        fwp_cmd_t    cs [4] = '{cPp, FWP_SECTOR_ERASE_CMD, FWP_SMALL_SECTOR_ERASE_CMD, cPp};
        logic        p;
        for (int k = 0; k < 16; k++) begin
            host.wsend(k[0] ? FWP_WRITE_ANY_REG_CMD : cWr, 32'h0,
                       {2'b00, k[3], 5'h00, 3'b000, k[2:0], 2'b00});
            rd(`FWP_REG_STATUS);
            chk(v[4:2], k[2:0]);
            rd(`FWP_REG_CONFIG);
            chk(v[5], k[3]);
            foreach (ad[j]) begin
                p = prot(k[2:0], k[3], ad[j]);
                op(cs[j % 4], ad[j], 8'h00, 1'b1, !p);
                if (p) begin
                    rd(`FWP_REG_STATUS);
                    chk(v[(cs[j % 4] == cPp) ? 6 : 5], 1'b1);
                    wr(`FWP_REG_CLEAR, 32'h60);
                end
            end
        end
    endtask : t_block

    task automatic t_sector;
        host.wsend(cWr, 32'h0, 16'h0004);
        @(posedge clk);
        ppbBit <= 1'b0;
        op(cPp, 32'h0000_1000, 8'h00, 1'b1, 1'b0);
        @(posedge clk);
        ppbBit <= 1'b1;
        dybBit <= 1'b0;
        op(FWP_SECTOR_ERASE_CMD, 32'h0000_1000, 8'h00, 1'b1, 1'b0);
        @(posedge clk);
        dybBit <= 1'b1;
        op(FWP_BULK_ERASE_CMD, 32'h0, 8'h00, 1'b1, 1'b0);
        host.wsend(cWr, 32'h0, 16'h0);
        op(FWP_BULK_ERASE_CMD, 32'h0, 8'h00, 1'b1, 1'b1);
        wr(`FWP_REG_CLEAR, 32'h60);
    endtask : t_sector

    task automatic t_otp;
        op(cOtp, 32'h20, 8'h5A, 1'b1, 1'b1);
        chk(lastGo.eccOn, 1'b1);
        op(cOtp, 32'h24, 8'h00, 1'b1, 1'b1);
        chk(lastGo.eccOn, 1'b0);
        rd(`FWP_REG_ECC_LO);
        chk(v, 32'h0000_0004);
        op(cOtp, 32'h30, 8'h00, 1'b1, 1'b1);
        chk(lastGo.eccOn, 1'b1);
        op(cOtp, 32'h10, 8'hFD, 1'b1, 1'b1);
        rd(`FWP_REG_LOCK);
        chk(v, 32'hFFFF_FFFD);
        op(cOtp, 32'h20, 8'h00, 1'b1, 1'b0);
        op(cOtp, 32'h10, 8'hFE, 1'b1, 1'b1);
        op(cOtp, 32'h18, 8'h00, 1'b1, 1'b0);
        op(cOtp, 32'h08, 8'h00, 1'b1, 1'b1);
        @(posedge clk);
        ppbBit <= 1'b0;
        op(cOtp, 32'h3FF, 8'h00, 1'b1, 1'b1);
        @(posedge clk);
        ppbBit <= 1'b1;
        wr(`FWP_REG_CLEAR, 32'h40);
        op(cOtp, 32'h400, 8'h00, 1'b1, 1'b0);
        rd(`FWP_REG_STATUS);
        chk(v[6], 1'b0);
        op(FWP_OTP_READ_CMD, 32'h400, 8'h00, 1'b0, 1'b1);
    endtask : t_otp

    task automatic t_freeze;
        host.wsend(cWr, 32'h0, 16'h0104);
        host.wsend(cWr, 32'h0, 16'h0100);
        rd(`FWP_REG_STATUS);
        chk(v[4:2], 3'h1);
        op(cOtp, 32'h40, 8'h00, 1'b1, 1'b0);
        rd(`FWP_REG_STATUS);
        chk(v[6], 1'b1);
        reset_dut();
        rd(`FWP_REG_CONFIG);
        chk(v, 32'h0);
    endtask : t_freeze

    task automatic t_wp;
        host.wsend(cWr, 32'h0, 16'h0080);
        @(posedge clk);
        wpN <= 1'b0;
        host.wsend(cWr, 32'h0, 16'h0008);
        rd(`FWP_REG_STATUS);
        chk(v[7:2], 6'h20);
        @(posedge clk);
        wpN <= 1'b1;
        host.wsend(cWr, 32'h0, 16'h0088);
        rd(`FWP_REG_STATUS);
        chk(v[7:2], 6'h22);
    endtask : t_wp

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        wpN = 1'b1;
        ppbBit = 1'b1;
        dybBit = 1'b1;
        busAddr = 8'h00;
        busWdata = 32'h0;
        busWr = 1'b0;
        busRd = 1'b0;
        fails = 0;
        checks_done = 0;
        goCnt = 0;
        reset_dut();
        t_reset();
        t_latch();
        t_block();
        t_sector();
        t_otp();
        t_freeze();
        t_wp();
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
